/* File: verilog/signal_monitor_gain_detect.sv */
`timescale 1ns/1ps
`default_nettype none
`include "monitor_defs.svh"

module signal_monitor_gain_detect
  import monitor_pkg::*;
#(
  parameter int SAMPLE_W = 14,
  parameter int MAG_W    = 13
)(
  input  wire logic                           MCLK,     // sample clock
  input  wire logic                           RESET,    // async, active high
  input  wire logic [1:0][SAMPLE_W-1:0]       SAMPLE,   // signed samples, ch 1..0
  input  wire logic [1:0][2:0]                FAST_LEVEL_PINS, // fast magnitude per channel
  input  wire logic                           REG_WR,   // register write strobe
  input  wire logic                           REG_RD,   // register read strobe
  input  wire logic [12:0]                    REG_ADDR, // register byte address
  input  wire logic [7:0]                     REG_WDATA, // write byte
  output logic      [7:0]                     REG_RDATA, // read byte, one cycle after strobe
  output level_flags_t [1:0]                  FLAGS     // indicator outputs per channel
);

  // configuration registers
  logic [2:0]         coarse_upper_level_reg;
  logic [MAG_W-1:0]   fine_upper_level_reg;
  logic [MAG_W-1:0]   fine_lower_level_reg;
  logic [15:0]        gain_dwell_time_reg;
  logic [23:0]        measure_period_reg;
  logic [2:0]         serial_en_reg;
  logic               mon_en_reg;
  mon_mode_t          mon_mode_reg;
  logic               ms_sel_reg;
  logic [1:0][19:0]   measure_result;
  logic [23:0]        period_eff;
  logic [4:0]         period_log2;
  logic               run_rms;
  logic               run_peak;
  logic               run_cross;

  // square root of a 40-bit value, bit by bit
  function automatic logic [19:0] isqrt(input logic [39:0] x);
    logic [19:0] r;
    logic [19:0] t;
    r = 20'h00000;
    for (int i = 19; i >= 0; i--)
    begin
      t = r | (20'h00001 << i);
      if ({20'h00000, t} * {20'h00000, t} <= {40'h0, x})
        r = t;
    end
    return r;
  endfunction : isqrt

  // register writes; multi-byte fields are little endian
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      coarse_upper_level_reg <= `RST_COARSE_UPPER;
      fine_upper_level_reg   <= `RST_FINE_UPPER;
      fine_lower_level_reg   <= `RST_FINE_LOWER;
      gain_dwell_time_reg    <= `RST_DWELL;
      measure_period_reg     <= `RST_PERIOD;
      serial_en_reg          <= 3'h0;
      mon_en_reg             <= 1'b0;
      mon_mode_reg           <= MODE_RMS;
      ms_sel_reg             <= 1'b0;
    end
    else if (REG_WR)
    begin
      unique case (REG_ADDR)
        `ADDR_COARSE_UPPER:  coarse_upper_level_reg <= REG_WDATA[2:0];
        `ADDR_FINE_UPPER_LO: fine_upper_level_reg[7:0] <= REG_WDATA;
        `ADDR_FINE_UPPER_HI: fine_upper_level_reg[12:8] <= REG_WDATA[4:0];
        `ADDR_FINE_LOWER_LO: fine_lower_level_reg[7:0] <= REG_WDATA;
        `ADDR_FINE_LOWER_HI: fine_lower_level_reg[12:8] <= REG_WDATA[4:0];
        `ADDR_DWELL_LO:      gain_dwell_time_reg[7:0] <= REG_WDATA;
        `ADDR_DWELL_HI:      gain_dwell_time_reg[15:8] <= REG_WDATA;
        `ADDR_SERIAL_CTRL:   serial_en_reg <= REG_WDATA[2:0];
        `ADDR_MON_CTRL:
        begin
          mon_en_reg   <= REG_WDATA[`MON_EN_BIT];
          mon_mode_reg <= mon_mode_t'(REG_WDATA[`MON_MODE_LSB +: 2]);   // one field for both channels
          ms_sel_reg   <= REG_WDATA[`MON_MS_BIT];
        end
        `ADDR_PERIOD_0:      measure_period_reg[7:0] <= REG_WDATA;
        `ADDR_PERIOD_1:      measure_period_reg[15:8] <= REG_WDATA;
        `ADDR_PERIOD_2:      measure_period_reg[23:16] <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // register reads; unmapped addresses return zero
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
    begin
      unique case (REG_ADDR)
        `ADDR_COARSE_UPPER:  REG_RDATA <= {5'h00, coarse_upper_level_reg};
        `ADDR_FINE_UPPER_LO: REG_RDATA <= fine_upper_level_reg[7:0];
        `ADDR_FINE_UPPER_HI: REG_RDATA <= {3'h0, fine_upper_level_reg[12:8]};
        `ADDR_FINE_LOWER_LO: REG_RDATA <= fine_lower_level_reg[7:0];
        `ADDR_FINE_LOWER_HI: REG_RDATA <= {3'h0, fine_lower_level_reg[12:8]};
        `ADDR_DWELL_LO:      REG_RDATA <= gain_dwell_time_reg[7:0];
        `ADDR_DWELL_HI:      REG_RDATA <= gain_dwell_time_reg[15:8];
        `ADDR_SERIAL_CTRL:   REG_RDATA <= {5'h00, serial_en_reg};
        `ADDR_MON_CTRL:      REG_RDATA <= {4'h0, ms_sel_reg, mon_mode_reg, mon_en_reg};
        `ADDR_PERIOD_0:      REG_RDATA <= measure_period_reg[7:0];
        `ADDR_PERIOD_1:      REG_RDATA <= measure_period_reg[15:8];
        `ADDR_PERIOD_2:      REG_RDATA <= measure_period_reg[23:16];
        13'h116:             REG_RDATA <= measure_result[0][7:0];
        13'h117:             REG_RDATA <= measure_result[0][15:8];
        13'h118:             REG_RDATA <= {4'h0, measure_result[0][19:16]};
        13'h119:             REG_RDATA <= measure_result[1][7:0];
        13'h11A:             REG_RDATA <= measure_result[1][15:8];
        13'h11B:             REG_RDATA <= {4'h0, measure_result[1][19:16]};
        default:             REG_RDATA <= 8'h00;
      endcase
    end
  end

  // short periods are raised to the minimum the timer supports
  always_comb
  begin
    period_eff  = (measure_period_reg < `PERIOD_MIN) ? `PERIOD_MIN : measure_period_reg;
    period_log2 = 5'h18;
    for (int i = 23; i >= 0; i--)
      if ((24'h000001 << i) >= period_eff)
        period_log2 = 5'(i);
  end

  // measurement selection, by mode field or serial enable
  assign run_rms   = (mon_mode_reg == MODE_RMS)  | serial_en_reg[`SER_RMS_BIT];
  assign run_peak  = (mon_mode_reg == MODE_PEAK) | serial_en_reg[`SER_PEAK_BIT];
  assign run_cross = mon_mode_reg[1] | serial_en_reg[`SER_CROSS_BIT];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      logic [MAG_W-1:0]    mag_reg;
      logic [2:0]          fast_reg;
      logic [15:0]         dwell_cnt_reg;
      logic [4:0]          held_reg;
      logic [23:0]         timer_reg;
      logic [MAG_W-1:0]    peak_reg;
      logic [MAG_W-1:0]    peak_hold_reg;
      logic [23:0]         acc_reg;
      logic [19:0]         power_hold_reg;
      logic [23:0]         cross_reg;
      logic [23:0]         cross_hold_reg;
      logic [SAMPLE_W-1:0] abs_val;
      logic [2*MAG_W-1:0]  square;
      logic [10:0]         power;
      logic [24:0]         acc_sum;
      logic [32:0]         ms_wide;
      logic [19:0]         ms_val;
      logic                period_end;
      level_flags_t        cond;
      // absolute value, saturated to the magnitude width
      always_comb
      begin
        abs_val = SAMPLE[ch][SAMPLE_W-1] ? SAMPLE_W'(-SAMPLE[ch]) : SAMPLE[ch];
        if (abs_val[SAMPLE_W-1])
          abs_val = {1'b0, {(SAMPLE_W-1){1'b1}}};
      end
      // first pipeline stage: magnitude and fast level
      always_ff @(posedge MCLK or posedge RESET)
      begin
        if (RESET)
        begin
          mag_reg  <= '0;
          fast_reg <= 3'h0;
        end
        else
        begin
          mag_reg  <= abs_val[MAG_W-1:0];
          fast_reg <= FAST_LEVEL_PINS[ch];
        end
      end
      // dwell counter, reset whenever magnitude rises to the lower level
      always_ff @(posedge MCLK or posedge RESET)
      begin
        if (RESET)
          dwell_cnt_reg <= 16'h0000;
        else if (mag_reg >= fine_lower_level_reg)
          dwell_cnt_reg <= 16'h0000;
        else if (dwell_cnt_reg != 16'hFFFE)                                        // stops one short so the +1 below never wraps
          dwell_cnt_reg <= dwell_cnt_reg + 16'h0001;
      end
      // raw conditions: fine flags from the magnitude, coarse and lower gain from the fast level, raise gain with the dwell count
      always_comb
      begin
        cond.fine_high_flag   = mag_reg > fine_upper_level_reg;
        cond.fine_low_flag    = mag_reg < fine_lower_level_reg;
        cond.coarse_high_flag = fast_reg > coarse_upper_level_reg;
        cond.lower_gain_out   = fast_reg > coarse_upper_level_reg;
        cond.raise_gain_out   = cond.fine_low_flag &&
                                ((dwell_cnt_reg + 16'h0001) >= gain_dwell_time_reg);
      end
      // output stage; a fresh assertion is held for at least two cycles
      always_ff @(posedge MCLK or posedge RESET)
      begin
        if (RESET)
        begin
          FLAGS[ch] <= '0;
          held_reg  <= 5'h00;
        end
        else
        begin
          FLAGS[ch] <= cond | (FLAGS[ch] & held_reg);
          held_reg  <= cond & ~FLAGS[ch];
        end
      end

      // power of one sample as 11-bit fraction of full scale
      always_comb
      begin
        square     = {{MAG_W{1'b0}}, mag_reg} * {{MAG_W{1'b0}}, mag_reg};
        power      = square[2*MAG_W-1 -: 11];
        acc_sum    = {1'b0, acc_reg} + {14'h0000, power};
        period_end = (timer_reg == 24'h000001);
        ms_wide    = ({9'h000, acc_reg} << `POWER_SHIFT) >> period_log2;
        ms_val     = (ms_wide[32:20] != 13'h0000) ? 20'hFFFFF : ms_wide[19:0];
      end

      // period timer, running only while the monitor is enabled
      always_ff @(posedge MCLK or posedge RESET)
      begin
        if (RESET)
          timer_reg <= `RST_PERIOD;
        else if (!mon_en_reg || period_end)
          timer_reg <= period_eff;
        else
          timer_reg <= timer_reg - 24'h000001;
      end

      // peak tracker; seeded from the current magnitude while idle
      always_ff @(posedge MCLK or posedge RESET)
      begin
        if (RESET)
        begin
          peak_reg      <= '0;
          peak_hold_reg <= '0;
        end
        else if (!mon_en_reg || !run_peak)
          peak_reg <= mag_reg;
        else if (period_end)
        begin
          peak_hold_reg <= (mag_reg > peak_reg) ? mag_reg : peak_reg;
          peak_reg      <= mag_reg;
        end
        else if (mag_reg > peak_reg)
          peak_reg <= mag_reg;
      end

      // power accumulator, saturating rather than wrapping
      always_ff @(posedge MCLK or posedge RESET)
      begin
        if (RESET)
        begin
          acc_reg        <= 24'h000000;
          power_hold_reg <= 20'h00000;
        end
        else if (!mon_en_reg || !run_rms)
          acc_reg <= 24'h000000;
        else if (period_end)
        begin
          power_hold_reg <= ms_sel_reg ? ms_val : isqrt({ms_val, 20'h00000});
          acc_reg        <= {13'h0000, power};
        end
        else
          acc_reg <= acc_sum[24] ? 24'hFFFFFF : acc_sum[23:0];
      end

      // crossing counter against the shared fine upper level
      always_ff @(posedge MCLK or posedge RESET)
      begin
        if (RESET)
        begin
          cross_reg      <= 24'h000000;
          cross_hold_reg <= 24'h000000;
        end
        else if (!mon_en_reg || !run_cross)
          cross_reg <= 24'h000000;
        else if (period_end)
        begin
          cross_hold_reg <= cross_reg;
          cross_reg      <= 24'h000000;
        end
        else if (mag_reg > fine_upper_level_reg)
          cross_reg <= cross_reg + 24'h000001;
      end

      // readable result follows the mode field; counts saturate at 20 bits
      always_comb
      begin
        unique case (mon_mode_reg)
          MODE_RMS:  measure_result[ch] = power_hold_reg;
          MODE_PEAK: measure_result[ch] = {7'h00, peak_hold_reg};
          MODE_CROSSA,
          MODE_CROSSB:
            measure_result[ch] = (cross_hold_reg[23:20] != 4'h0) ? 20'hFFFFF : cross_hold_reg[19:0];
        endcase
      end
    end
  endgenerate
endmodule : signal_monitor_gain_detect
`default_nettype wire

/* File: verilog/monitor_defs.svh */
`ifndef MONITOR_DEFS_SVH
`define MONITOR_DEFS_SVH
// register byte addresses
`define ADDR_COARSE_UPPER   13'h105
`define ADDR_FINE_UPPER_LO  13'h106
`define ADDR_FINE_UPPER_HI  13'h107
`define ADDR_FINE_LOWER_LO  13'h108
`define ADDR_FINE_LOWER_HI  13'h109
`define ADDR_DWELL_LO       13'h10A
`define ADDR_DWELL_HI       13'h10B
`define ADDR_SERIAL_CTRL    13'h111
`define ADDR_MON_CTRL       13'h112
`define ADDR_PERIOD_0       13'h113
`define ADDR_PERIOD_1       13'h114
`define ADDR_PERIOD_2       13'h115
`define ADDR_RESULT_BASE    13'h116
`define ADDR_RESULT_LAST    13'h11B
// monitor control fields
`define MON_EN_BIT          0
`define MON_MODE_LSB        1
`define MON_MS_BIT          3
// serial enable fields
`define SER_RMS_BIT         0
`define SER_PEAK_BIT        1
`define SER_CROSS_BIT       2
// reset values and limits
`define RST_COARSE_UPPER    3'h7
`define RST_FINE_UPPER      13'h1FFF
`define RST_FINE_LOWER      13'h0000
`define RST_DWELL           16'h0001
`define RST_PERIOD          24'h000080
`define PERIOD_MIN          24'h000080
`define POWER_SHIFT         9
`endif

/* File: verilog/monitor_pkg.sv */
`default_nettype none
package monitor_pkg;
  // monitor mode field encoding
  typedef enum logic [1:0] {
    MODE_RMS    = 2'b00,
    MODE_PEAK   = 2'b01,
    MODE_CROSSA = 2'b10,
    MODE_CROSSB = 2'b11
  } mon_mode_t;

  // per-channel level indicators
  typedef struct packed {
    logic fine_high_flag;
    logic fine_low_flag;
    logic coarse_high_flag;
    logic raise_gain_out;
    logic lower_gain_out;
  } level_flags_t;
endpackage : monitor_pkg
`default_nettype wire

/* File: sim/monitor_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module monitor_checker
  import monitor_pkg::*;
#(
  parameter int SAMPLE_W = 14,
  parameter int MAG_W    = 13
)(
  input wire logic                     MCLK,            // sample clock
  input wire logic                     RESET,           // async reset
  input wire logic [1:0][SAMPLE_W-1:0] SAMPLE,          // samples
  input wire logic [1:0][2:0]          FAST_LEVEL_PINS, // fast magnitude
  input wire logic                     REG_WR,          // write strobe
  input wire logic                     REG_RD,          // read strobe
  input wire logic [12:0]              REG_ADDR,        // byte address
  input wire logic [7:0]               REG_WDATA,       // write byte
  input wire logic [7:0]               REG_RDATA,       // read byte
  input wire level_flags_t [1:0]       FLAGS            // indicators
);
  logic [2:0]          coarse_reg;
  logic [12:0]         upper_reg;
  logic [12:0]         lower_reg;
  logic [15:0]         dwell_reg;
  logic [15:0]         below_reg;
  logic [15:0]         below_now;
  logic [15:0]         dwell_eff;
  logic [4:0]          quiet_reg;
  logic [SAMPLE_W-1:0] neg0;
  logic [MAG_W-1:0]    mag0;
  logic                quiet;

  // channel 0 magnitude, full-scale negative saturates
  assign neg0      = -SAMPLE[0];
  assign mag0      = SAMPLE[0][SAMPLE_W-1] ? (neg0[SAMPLE_W-1] ? '1 : MAG_W'(neg0)) : MAG_W'(SAMPLE[0]);
  assign below_now = (mag0 < lower_reg) ? ((below_reg == 16'hFFFF) ? below_reg : below_reg + 16'h1) : 16'h0;
  assign dwell_eff = (dwell_reg == 16'h0) ? 16'h1 : dwell_reg;
  assign quiet     = (quiet_reg == 5'h1F) && !REG_WR; // settles out level changes and stale dwell history

  // shadow of the level registers, taken from the write strobes
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      coarse_reg <= 3'h7;
      upper_reg  <= 13'h1FFF;
      lower_reg  <= 13'h0000;
      dwell_reg  <= 16'h0001;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == 13'h105) coarse_reg <= REG_WDATA[2:0];
      if (REG_ADDR == 13'h106) upper_reg[7:0] <= REG_WDATA;
      if (REG_ADDR == 13'h107) upper_reg[12:8] <= REG_WDATA[4:0];
      if (REG_ADDR == 13'h108) lower_reg[7:0] <= REG_WDATA;
      if (REG_ADDR == 13'h109) lower_reg[12:8] <= REG_WDATA[4:0];
      if (REG_ADDR == 13'h10A) dwell_reg[7:0] <= REG_WDATA;
      if (REG_ADDR == 13'h10B) dwell_reg[15:8] <= REG_WDATA;
    end
  end

  // quiet time since last write and run of low samples
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      quiet_reg <= 5'h0;
      below_reg <= 16'h0;
    end
    else
    begin
      quiet_reg <= REG_WR ? 5'h0 : ((quiet_reg == 5'h1F) ? quiet_reg : quiet_reg + 5'h1);
      below_reg <= below_now;
    end
  end

  a_fine_high_set: assert property (@(posedge MCLK) disable iff (RESET)
    quiet && mag0 > upper_reg |-> ##2 FLAGS[0].fine_high_flag) else $error("fine high flag missing");
  a_fine_high_clear: assert property (@(posedge MCLK) disable iff (RESET)
    (quiet && mag0 <= upper_reg) [*2] |-> ##2 !FLAGS[0].fine_high_flag) else $error("fine high flag stuck");
  a_fine_low_set: assert property (@(posedge MCLK) disable iff (RESET)
    quiet && mag0 < lower_reg |-> ##2 FLAGS[0].fine_low_flag) else $error("fine low flag missing");
  a_coarse_set: assert property (@(posedge MCLK) disable iff (RESET)
    quiet && FAST_LEVEL_PINS[0] > coarse_reg |-> ##2 FLAGS[0].coarse_high_flag) else $error("coarse flag late");
  a_gain_pair: assert property (@(posedge MCLK) disable iff (RESET)
    FLAGS[1].lower_gain_out == FLAGS[1].coarse_high_flag) else $error("lower gain differs from coarse");
  a_lower_gain_set: assert property (@(posedge MCLK) disable iff (RESET)
    quiet && FAST_LEVEL_PINS[0] > coarse_reg |-> ##2 FLAGS[0].lower_gain_out) else $error("lower gain missing");
  a_lower_gain_clear: assert property (@(posedge MCLK) disable iff (RESET)
    (quiet && FAST_LEVEL_PINS[0] <= coarse_reg) [*2] |-> ##2 !FLAGS[0].lower_gain_out) else $error("lower gain stuck");
  a_flag_min_hold: assert property (@(posedge MCLK) disable iff (RESET)
    $rose(FLAGS[0].coarse_high_flag) |=> FLAGS[0].coarse_high_flag) else $error("flag shorter than 2 cycles");
  a_raise_after_dwell: assert property (@(posedge MCLK) disable iff (RESET)
    quiet && below_now >= dwell_eff |-> ##2 FLAGS[0].raise_gain_out) else $error("raise gain missing");
  a_raise_not_early: assert property (@(posedge MCLK) disable iff (RESET)
    quiet && $rose(FLAGS[0].raise_gain_out) |-> $past(below_now, 2) >= dwell_eff) else $error("raise gain early");
  a_rdata_hold: assert property (@(posedge MCLK) disable iff (RESET)
    !REG_RD |=> $stable(REG_RDATA)) else $error("read data changed without read");
  a_unmapped_zero: assert property (@(posedge MCLK) disable iff (RESET)
    REG_RD && (REG_ADDR < 13'h105 || REG_ADDR > 13'h11B) |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
endmodule : monitor_checker

bind signal_monitor_gain_detect monitor_checker #(.SAMPLE_W(SAMPLE_W), .MAG_W(MAG_W)) chk (.MCLK(MCLK),
  .RESET(RESET), .SAMPLE(SAMPLE), .FAST_LEVEL_PINS(FAST_LEVEL_PINS), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FLAGS(FLAGS));
`default_nettype wire

/* File: sim/sample_source.sv */
`timescale 1ns/1ps
`default_nettype none
module sample_source #(
  parameter int SAMPLE_W = 14
)(
  input  wire logic                     mclk,       // sample clock
  input  wire logic                     reset,      // async reset
  input  wire logic [1:0][12:0]         level_mag,  // wanted magnitude
  input  wire logic [1:0]               level_neg,  // negative sample
  input  wire logic [1:0][2:0]          level_fast, // wanted fast level
  output logic      [1:0][SAMPLE_W-1:0] sample_out, // samples to monitor
  output logic      [1:0][2:0]          fast_out    // fast level to monitor
);
  // fresh sample every clock, sign per channel so both halves of the range are exercised
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sample_out <= '0;
      fast_out   <= '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        sample_out[c] <= level_neg[c] ? -SAMPLE_W'(level_mag[c]) : SAMPLE_W'(level_mag[c]);
        fast_out[c]   <= level_fast[c];
      end
    end
  end
endmodule : sample_source
`default_nettype wire

/* File: sim/test_signal_monitor_gain_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module test_signal_monitor_gain_detect;
  import monitor_pkg::*;
  logic               MCLK;
  logic               RESET;
  logic [1:0][13:0]   SAMPLE;
  logic [1:0][2:0]    FAST_LEVEL_PINS;
  logic               REG_WR;
  logic               REG_RD;
  logic [12:0]        REG_ADDR;
  logic [7:0]         REG_WDATA;
  logic [7:0]         REG_RDATA;
  level_flags_t [1:0] FLAGS;
  logic [1:0][12:0]   level_mag;
  logic [1:0][2:0]    level_fast;
  logic [7:0]         rd_byte;
  int                 fail_count;
  int                 comparisons;
  // defaults after reset; last entry is unmapped
  logic [12:0] def_addr [10] = '{13'h105, 13'h106, 13'h107, 13'h108, 13'h109, 13'h10A, 13'h10B, 13'h112, 13'h113, 13'h100};
  logic [7:0]  def_val  [10] = '{8'h07, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00};
  // control value, channel levels and expected results per monitor mode
  logic [7:0]  mode_ctrl [5] = '{8'h03, 8'h05, 8'h07, 8'h01, 8'h09};
  logic [12:0] mode_m0   [5] = '{13'h2BC, 13'h5DC, 13'h5DC, 13'h1000, 13'h1000};
  logic [12:0] mode_m1   [5] = '{13'h12C, 13'h032, 13'h032, 13'h1000, 13'h1000};
  logic [19:0] mode_e0   [5] = '{20'h002BC, 20'h0007F, 20'h0007F, 20'h80000, 20'h40000};
  logic [19:0] mode_e1   [5] = '{20'h0012C, 20'h00000, 20'h00000, 20'h80000, 20'h40000};

  signal_monitor_gain_detect dut (.MCLK(MCLK), .RESET(RESET), .SAMPLE(SAMPLE), .FAST_LEVEL_PINS(FAST_LEVEL_PINS),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .FLAGS(FLAGS));
  sample_source src (.mclk(MCLK), .reset(RESET), .level_mag(level_mag), .level_neg(2'b10),
    .level_fast(level_fast), .sample_out(SAMPLE), .fast_out(FAST_LEVEL_PINS));

  // 10 MHz sample clock
  initial
  begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask : wr

  // strobe is taken at the second edge, data is settled just after it
  task automatic rd(input logic [12:0] a);
    @(posedge MCLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 rd_byte = REG_RDATA;
  endtask : rd

  // result period is long, so read until the expected value shows, bounded
  task automatic poll(input int ch, input logic [19:0] exp);
    logic [23:0] v;
    v = '0;
    for (int i = 0; i < 200; i++)
    begin
      for (int b = 0; b < 3; b++)
      begin
        rd(13'h116 + 13'(3 * ch + b));
        v = {rd_byte, v[23:8]};
      end
      if (v === {4'h0, exp}) break;
    end
    check(v, {4'h0, exp});
  endtask : poll

  task automatic set_level(input logic [12:0] m0, input logic [12:0] m1, input logic [2:0] f);
    @(posedge MCLK);
    level_mag  <= {m1, m0};
    level_fast <= {f, f};
  endtask : set_level

  task automatic final_report;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // hang guard, well above the roughly 1500 cycles the tests take
  initial
  begin
    repeat (40000) @(posedge MCLK);
    fail_count++;
    final_report();
  end

  initial
  begin
    RESET       = 1'b1;
    REG_WR      = 1'b0;
    REG_RD      = 1'b0;
    REG_ADDR    = '0;
    REG_WDATA   = '0;
    level_mag   = '0;
    level_fast  = '0;
    fail_count  = 0;
    comparisons = 0;
    repeat (8) @(posedge MCLK);
    RESET <= 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      rd(def_addr[i]);
      check(24'(rd_byte), 24'(def_val[i]));
    end
    // coarse 3, fine upper 1000, fine lower 100, dwell 5
    wr(13'h105, 8'h03);
    wr(13'h106, 8'hE8);
    wr(13'h107, 8'h03);
    wr(13'h108, 8'h64);
    wr(13'h10A, 8'h05);
    rd(13'h106);
    check(24'(rd_byte), 24'hE8);
    // large signal both signs: fine high, coarse high and lower gain
    set_level(13'h5DC, 13'h5DC, 3'h5);
    repeat (6) @(posedge MCLK);
    #1 check(24'(FLAGS), 24'h2B5);
    // fast level equal to coarse level is not above it
    set_level(13'h5DC, 13'h5DC, 3'h3);
    repeat (6) @(posedge MCLK);
    #1 check(24'(FLAGS), 24'h210);
    // small signal: fine low at once, raise gain only after the dwell
    set_level(13'h032, 13'h032, 3'h0);
    repeat (4) @(posedge MCLK);
    #1 check(24'(FLAGS), 24'h108);
    repeat (8) @(posedge MCLK);
    #1 check(24'(FLAGS), 24'h14A);
    // period first, then each monitor mode with a level and expected result per channel
    wr(13'h113, 8'h80);
    for (int i = 0; i < 5; i++)
    begin
      wr(13'h112, 8'h00);
      set_level(mode_m0[i], mode_m1[i], 3'h0);
      wr(13'h112, mode_ctrl[i]);
      poll(0, mode_e0[i]);
      poll(1, mode_e1[i]);
      if (i == 0)
      begin
        set_level(13'h384, 13'h12C, 3'h0);
        set_level(13'h2BC, 13'h12C, 3'h0);
        poll(0, 20'h00384);
        poll(0, 20'h002BC);
      end
    end
    // peak engine started by its serial enable alone, seen once the mode field selects peak
    wr(13'h111, 8'h02);
    set_level(13'h4B0, 13'h12C, 3'h0);
    wr(13'h112, 8'h01);
    repeat (300) @(posedge MCLK);
    wr(13'h112, 8'h02);
    poll(0, 20'h004B0);
    poll(1, 20'h0012C);
    final_report();
  end
endmodule : test_signal_monitor_gain_detect
`default_nettype wire
